//--- hw/codec_power_pkg.sv
// Contract
// - reg 09h bit 9: right PGA, reset 0
// - reg 09h bit 8: left PGA, reset 0
// - reg 09h bit 7: right input mixer, reset 0
// - reg 09h bit 6: left input mixer, reset 0
// - reg 09h bit 1: right output mixer, reset 0
// - reg 09h bit 0: left output mixer, reset 0
// - reg 0Bh bit 13: highpass filter, reset 1
// - reg 0Bh bit 8: timeout slow clock, reset 0
package codec_power_pkg;

  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  // register offsets
  localparam addr_t IN_OUT_MIX_OFFSET   = 8'h09;
  localparam addr_t OUT_DRIVER_OFFSET   = 8'h0a;
  localparam addr_t CONV_CLOCK_OFFSET   = 8'h0b;

  // number of registers and their slot order
  localparam int NUM_REGS  = 3;
  localparam int SLOT_MIX  = 0;
  localparam int SLOT_DRV  = 1;
  localparam int SLOT_CONV = 2;

  // input_output_mixer_power field positions
  localparam int AUX_RIGHT_AMP_ON_POS    = 11;
  localparam int AUX_LEFT_AMP_ON_POS     = 10;
  localparam int RIGHT_PGA_ON_POS        = 9;
  localparam int LEFT_PGA_ON_POS         = 8;
  localparam int RIGHT_IN_MIXER_ON_POS   = 7;
  localparam int LEFT_IN_MIXER_ON_POS    = 6;
  localparam int FOURTH_OUTPUT_ON_POS    = 5;
  localparam int THIRD_OUTPUT_ON_POS     = 4;
  localparam int RIGHT_OUT_MIXER_ON_POS  = 1;
  localparam int LEFT_OUT_MIXER_ON_POS   = 0;

  // output_driver_power field positions
  localparam int BEEP_PATH_ON_POS            = 7;
  localparam int SECOND_OUTPUT_RIGHT_ON_POS  = 3;
  localparam int SECOND_OUTPUT_LEFT_ON_POS   = 2;
  localparam int FIRST_OUTPUT_RIGHT_ON_POS   = 1;
  localparam int FIRST_OUTPUT_LEFT_ON_POS    = 0;

  // converter_clock_power field positions
  localparam int CODEC_SYS_CLOCK_ON_POS    = 14;
  localparam int ADC_HIGHPASS_ON_POS       = 13;
  localparam int TIMEOUT_SLOW_CLOCK_ON_POS = 8;
  localparam int RIGHT_DAC_ON_POS          = 5;
  localparam int LEFT_DAC_ON_POS           = 4;
  localparam int RIGHT_ADC_ON_POS          = 3;
  localparam int LEFT_ADC_ON_POS           = 2;

  // implemented-bit masks, built from the field positions
  localparam word_t IN_OUT_MIX_MASK = word_t'(
      (1 << AUX_RIGHT_AMP_ON_POS) | (1 << AUX_LEFT_AMP_ON_POS) |
      (1 << RIGHT_PGA_ON_POS) | (1 << LEFT_PGA_ON_POS) |
      (1 << RIGHT_IN_MIXER_ON_POS) | (1 << LEFT_IN_MIXER_ON_POS) |
      (1 << FOURTH_OUTPUT_ON_POS) | (1 << THIRD_OUTPUT_ON_POS) |
      (1 << RIGHT_OUT_MIXER_ON_POS) | (1 << LEFT_OUT_MIXER_ON_POS));
  localparam word_t OUT_DRIVER_MASK = word_t'(
      (1 << BEEP_PATH_ON_POS) | (1 << SECOND_OUTPUT_RIGHT_ON_POS) |
      (1 << SECOND_OUTPUT_LEFT_ON_POS) | (1 << FIRST_OUTPUT_RIGHT_ON_POS) |
      (1 << FIRST_OUTPUT_LEFT_ON_POS));
  localparam word_t CONV_CLOCK_MASK = word_t'(
      (1 << CODEC_SYS_CLOCK_ON_POS) | (1 << ADC_HIGHPASS_ON_POS) |
      (1 << TIMEOUT_SLOW_CLOCK_ON_POS) | (1 << RIGHT_DAC_ON_POS) |
      (1 << LEFT_DAC_ON_POS) | (1 << RIGHT_ADC_ON_POS) | (1 << LEFT_ADC_ON_POS));

  // reset values
  localparam word_t IN_OUT_MIX_RESET = 16'h0000;
  localparam word_t OUT_DRIVER_RESET = 16'h0000;
  localparam word_t CONV_CLOCK_RESET = word_t'(1 << ADC_HIGHPASS_ON_POS);

  // per-slot tables used by the generate loop
  localparam addr_t REG_OFFSET [NUM_REGS] = '{IN_OUT_MIX_OFFSET, OUT_DRIVER_OFFSET,
                                              CONV_CLOCK_OFFSET};
  localparam word_t REG_MASK   [NUM_REGS] = '{IN_OUT_MIX_MASK, OUT_DRIVER_MASK,
                                              CONV_CLOCK_MASK};
  localparam word_t REG_RESET  [NUM_REGS] = '{IN_OUT_MIX_RESET, OUT_DRIVER_RESET,
                                              CONV_CLOCK_RESET};

  // stereo adc pair bits
  localparam word_t ADC_PAIR_MASK = word_t'((1 << RIGHT_ADC_ON_POS) | (1 << LEFT_ADC_ON_POS));

endpackage : codec_power_pkg

//--- hw/power_reg_word.sv
`timescale 1ns/1ns
// one masked power-enable register word
module power_reg_word #(
  parameter codec_power_pkg::word_t WORD_MASK = 16'hffff,
  parameter codec_power_pkg::word_t RESET_VAL = 16'h0000
) (
  // clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   nrst_in,
  // write side
  input  wire logic                   wr_in,
  input  wire codec_power_pkg::word_t wdata_in,
  // stored word
  output      codec_power_pkg::word_t q_out
);
  import codec_power_pkg::*;

  word_t next_q;  // value for the next edge

  // load masked data on a write, hold otherwise
  always_comb begin
    next_q = q_out;
    if (wr_in) begin
      next_q = wdata_in & WORD_MASK;
    end
  end

  // register only; reset value is a masked constant
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_out <= RESET_VAL & WORD_MASK;
    end else begin
      q_out <= next_q;
    end
  end

endmodule : power_reg_word

//--- hw/codec_power_enable_regs.sv
`timescale 1ns/1ns
// three codec power-enable registers behind a simple register port
module codec_power_enable_regs (
  // clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   nrst_in,
  // register port
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  input  wire codec_power_pkg::addr_t reg_addr_in,
  input  wire codec_power_pkg::word_t reg_wdata_in,
  output      codec_power_pkg::word_t reg_rdata_out,
  output      logic                   reg_rvalid_out,
  output      logic                   reg_addr_err_out,
  // input and mixer enables
  output      logic                   aux_right_amp_on_out,
  output      logic                   aux_left_amp_on_out,
  output      logic                   right_pga_on_out,
  output      logic                   left_pga_on_out,
  output      logic                   right_in_mixer_on_out,
  output      logic                   left_in_mixer_on_out,
  output      logic                   fourth_output_on_out,
  output      logic                   third_output_on_out,
  output      logic                   right_out_mixer_on_out,
  output      logic                   left_out_mixer_on_out,
  // output driver enables
  output      logic                   beep_path_on_out,
  output      logic                   second_output_right_on_out,
  output      logic                   second_output_left_on_out,
  output      logic                   first_output_right_on_out,
  output      logic                   first_output_left_on_out,
  // converter and clock enables
  output      logic                   codec_sys_clock_on_out,
  output      logic                   adc_highpass_on_out,
  output      logic                   timeout_slow_clock_on_out,
  output      logic                   right_dac_on_out,
  output      logic                   left_dac_on_out,
  output      logic                   right_adc_on_out,
  output      logic                   left_adc_on_out,
  // stereo adc pair started by one write
  output      logic                   adc_pair_start_out
);
  import codec_power_pkg::*;

  // decode and storage
  // hit is one-hot or all zero, since the offsets are distinct
  logic [NUM_REGS-1:0] hit;             // address matches slot
  logic [NUM_REGS-1:0] slot_wr;         // write strobe per slot
  word_t               word [NUM_REGS]; // stored register words
  logic                any_hit;         // address maps to a register

  // read pipeline next values
  word_t               next_rdata;      // next read data
  logic                next_rvalid;     // next read-valid pulse
  logic                next_addr_err;   // next unmapped-access pulse

  // stereo pair detection next value
  // the pair check reads the stored word, not the bus data alone
  logic                next_pair_start; // both adcs turned on together
  word_t               old_conv;        // converter word before write

  // per-register address decode and storage
  // one register word per slot; masks and reset values come from the package
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      // match this register's offset
      assign hit[g]     = (reg_addr_in == REG_OFFSET[g]);
      // write lands in this register only; the offsets are distinct,
      // so at most one slot is struck per cycle
      assign slot_wr[g] = reg_wr_in & hit[g];

      power_reg_word #(
        // only listed bits keep what is written
        .WORD_MASK (REG_MASK[g]),
        // highpass bit of the converter word resets to one
        .RESET_VAL (REG_RESET[g])
      ) power_reg_word_inst (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .wr_in      (slot_wr[g]),
        .wdata_in   (reg_wdata_in),
        .q_out      (word[g])
      );
    end
  endgenerate

  // any register at this address
  // reads and writes both count, so a stray write is flagged as well
  assign any_hit = |hit;

  // converter word as it stood before any write this cycle
  // (the flop output, not the incoming write data)
  assign old_conv = word[SLOT_CONV];

  // read mux, valid pulse and unmapped-access flag
  // the mux reads the stored words before this edge, so a read and a
  // write to one offset in the same cycle return the old contents
  always_comb begin
    // defaults: nothing to answer
    next_rdata    = 16'h0000;
    next_rvalid   = 1'b0;
    next_addr_err = 1'b0;
    if (reg_rd_in) begin
      // answer every read one cycle later
      next_rvalid = 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
        if (hit[i]) begin
          // at most one slot hits; its word is already masked
          next_rdata = word[i];
        end
      end
    end
    // flag either kind of access to an unmapped offset
    if ((reg_rd_in || reg_wr_in) && !any_hit) begin
      // unmapped access: reads give zero, writes dropped
      next_addr_err = 1'b1;
    end
  end

  // read pipeline registers
  // registering here keeps every port answer on a flop
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // nothing pending out of reset
      reg_rdata_out    <= 16'h0000;
      reg_rvalid_out   <= 1'b0;
      reg_addr_err_out <= 1'b0;
    end else begin
      // one-cycle pulses, data back to zero when idle
      reg_rdata_out    <= next_rdata;
      reg_rvalid_out   <= next_rvalid;
      reg_addr_err_out <= next_addr_err;
    end
  end

  // flag a write that turns both adcs on from both off
  // comparing with the word before the write keeps a rewrite of a
  // running pair, or a second write that finishes a split enable,
  // from raising the pulse
  always_comb begin
    // default: no pulse
    next_pair_start = 1'b0;
    if (slot_wr[SLOT_CONV] &&
        ((reg_wdata_in & ADC_PAIR_MASK) == ADC_PAIR_MASK) &&
        ((old_conv & ADC_PAIR_MASK) == 16'h0000)) begin
      // both bits set by this one write
      next_pair_start = 1'b1;
    end
  end

  // pair start pulse register
  // one-cycle pulse, cleared by the next edge
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // no pulse out of reset
      adc_pair_start_out <= 1'b0;
    end else begin
      // follow the detector
      adc_pair_start_out <= next_pair_start;
    end
  end

  // input and mixer enables straight from the stored word; each bit is a
  // flop inside its register word, so a write reaches the pin at the edge
  // that takes it and reset clears the pin together with the word
  // aux right amplifier
  assign aux_right_amp_on_out   = word[SLOT_MIX][AUX_RIGHT_AMP_ON_POS];
  assign aux_left_amp_on_out    = word[SLOT_MIX][AUX_LEFT_AMP_ON_POS];
  assign right_pga_on_out       = word[SLOT_MIX][RIGHT_PGA_ON_POS];
  assign left_pga_on_out        = word[SLOT_MIX][LEFT_PGA_ON_POS];
  assign right_in_mixer_on_out  = word[SLOT_MIX][RIGHT_IN_MIXER_ON_POS];
  assign left_in_mixer_on_out   = word[SLOT_MIX][LEFT_IN_MIXER_ON_POS];
  assign fourth_output_on_out   = word[SLOT_MIX][FOURTH_OUTPUT_ON_POS];
  assign third_output_on_out    = word[SLOT_MIX][THIRD_OUTPUT_ON_POS];
  assign right_out_mixer_on_out = word[SLOT_MIX][RIGHT_OUT_MIXER_ON_POS];
  assign left_out_mixer_on_out  = word[SLOT_MIX][LEFT_OUT_MIXER_ON_POS];

  // output driver enables, all off after reset; bits 6 to 4 and the
  // upper byte of this word hold no flop and read zero
  // beep mixer path
  assign beep_path_on_out           = word[SLOT_DRV][BEEP_PATH_ON_POS];
  assign second_output_right_on_out = word[SLOT_DRV][SECOND_OUTPUT_RIGHT_ON_POS];
  assign second_output_left_on_out  = word[SLOT_DRV][SECOND_OUTPUT_LEFT_ON_POS];
  assign first_output_right_on_out  = word[SLOT_DRV][FIRST_OUTPUT_RIGHT_ON_POS];
  assign first_output_left_on_out   = word[SLOT_DRV][FIRST_OUTPUT_LEFT_ON_POS];

  // converter and clock enables; the highpass bit is the only one that
  // comes out of reset on, so a cleared converter word reads 2000h
  // codec system clock gate
  assign codec_sys_clock_on_out    = word[SLOT_CONV][CODEC_SYS_CLOCK_ON_POS];
  assign adc_highpass_on_out       = word[SLOT_CONV][ADC_HIGHPASS_ON_POS];
  assign timeout_slow_clock_on_out = word[SLOT_CONV][TIMEOUT_SLOW_CLOCK_ON_POS];
  assign right_dac_on_out          = word[SLOT_CONV][RIGHT_DAC_ON_POS];
  assign left_dac_on_out           = word[SLOT_CONV][LEFT_DAC_ON_POS];
  assign right_adc_on_out          = word[SLOT_CONV][RIGHT_ADC_ON_POS];
  assign left_adc_on_out           = word[SLOT_CONV][LEFT_ADC_ON_POS];

endmodule : codec_power_enable_regs

//--- tb/codec_power_enable_regs_checker.sv
`timescale 1ns/1ns
// watches the register port and selected enables of the power bank
module codec_power_enable_regs_checker (
  // clock and reset
  input wire logic                   ref_clk_in,
  input wire logic                   nrst_in,
  // register port
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire codec_power_pkg::addr_t reg_addr_in,
  input wire codec_power_pkg::word_t reg_wdata_in,
  input wire codec_power_pkg::word_t reg_rdata_out,
  input wire logic                   reg_rvalid_out,
  input wire logic                   reg_addr_err_out,
  // enables under watch
  input wire logic                   right_pga_on_out,
  input wire logic                   left_pga_on_out,
  input wire logic                   adc_highpass_on_out,
  input wire logic                   timeout_slow_clock_on_out,
  input wire logic                   right_adc_on_out,
  input wire logic                   left_adc_on_out,
  input wire logic                   adc_pair_start_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  logic wr9;  // write to the mixer register
  logic wrb;  // write to the converter register
  logic bad;  // access to an unmapped offset
  assign wr9 = reg_wr_in && (reg_addr_in == 8'h09);
  assign wrb = reg_wr_in && (reg_addr_in == 8'h0b);
  assign bad = (reg_wr_in || reg_rd_in) && (reg_addr_in < 8'h09 || reg_addr_in > 8'h0b);
  AST_RD_ANSWER: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered next cycle");
  AST_RD_IDLE: assert property (!reg_rvalid_out |-> reg_rdata_out == 16'h0000)
    else $error("read data not zero while idle");
  AST_PGA_R: assert property (wr9 |=> right_pga_on_out == $past(reg_wdata_in[9]))
    else $error("right pga enable does not follow write");
  AST_PGA_L: assert property (wr9 |=> left_pga_on_out == $past(reg_wdata_in[8]))
    else $error("left pga enable does not follow write");
  AST_HIGHPASS: assert property (wrb |=> adc_highpass_on_out == $past(reg_wdata_in[13]))
    else $error("highpass enable does not follow write");
  AST_SLOW_CLK: assert property (wrb |=> timeout_slow_clock_on_out == $past(reg_wdata_in[8]))
    else $error("slow clock enable does not follow write");
  AST_HOLD: assert property (!reg_wr_in |=> $stable(right_pga_on_out))
    else $error("enable changed without a write");
  AST_ADDR_ERR: assert property (bad |=> reg_addr_err_out)
    else $error("unmapped access not flagged");
  AST_PAIR: assert property (adc_pair_start_out |-> right_adc_on_out && left_adc_on_out)
    else $error("pair pulse without both converters on");
  // main scenarios
  COV_PAIR: cover property (adc_pair_start_out);
  COV_BAD: cover property (bad ##1 reg_addr_err_out);
  COV_HIGHPASS_OFF: cover property (wrb ##1 !adc_highpass_on_out);
endmodule : codec_power_enable_regs_checker

//--- tb/codec_power_enable_regs_tb.sv
`timescale 1ns/1ns
// self-checking bench for the three power-enable registers
module codec_power_enable_regs_tb;
  import codec_power_pkg::*;
  logic      ref_clk_in, nrst_in, reg_wr_in, reg_rd_in;  // driven inputs
  addr_t     reg_addr_in;                                 // access offset
  word_t     reg_wdata_in, reg_rdata_out;                 // data both ways
  word_t     m [NUM_REGS];                                // expected words
  logic      reg_rvalid_out, reg_addr_err_out, adc_pair_start_out;
  wire [15:0] a9, aa, ab;                                 // enables by register
  int        n_mismatch, num_checks;
  codec_power_enable_regs codec_power_enable_regs_inst (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .reg_addr_err_out(reg_addr_err_out),
    .aux_right_amp_on_out(a9[11]), .aux_left_amp_on_out(a9[10]),
    .right_pga_on_out(a9[9]), .left_pga_on_out(a9[8]),
    .right_in_mixer_on_out(a9[7]), .left_in_mixer_on_out(a9[6]),
    .fourth_output_on_out(a9[5]), .third_output_on_out(a9[4]),
    .right_out_mixer_on_out(a9[1]), .left_out_mixer_on_out(a9[0]),
    .beep_path_on_out(aa[7]), .second_output_right_on_out(aa[3]),
    .second_output_left_on_out(aa[2]), .first_output_right_on_out(aa[1]),
    .first_output_left_on_out(aa[0]), .codec_sys_clock_on_out(ab[14]),
    .adc_highpass_on_out(ab[13]), .timeout_slow_clock_on_out(ab[8]),
    .right_dac_on_out(ab[5]), .left_dac_on_out(ab[4]),
    .right_adc_on_out(ab[3]), .left_adc_on_out(ab[2]),
    .adc_pair_start_out(adc_pair_start_out));
  // bits with no enable behind them read as zero
  assign a9[15:12] = 4'h0;
  assign a9[3:2]   = 2'h0;
  assign aa[15:8]  = 8'h00;
  assign aa[6:4]   = 3'h0;
  assign ab[15]    = 1'b0;
  assign ab[12:9]  = 4'h0;
  assign ab[7:6]   = 2'h0;
  assign ab[1:0]   = 2'h0;
  // clock at 4 ns
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // counted compare
  task automatic chk(input word_t got, input word_t exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // slot of an offset, -1 when unmapped
  function automatic int slot(input addr_t a);
    for (int i = 0; i < NUM_REGS; i++) if (REG_OFFSET[i] === a) return i;
    return -1;
  endfunction : slot
  // every enable against the expected words
  task automatic chk_en();
    chk(a9 & IN_OUT_MIX_MASK, m[SLOT_MIX]);
    chk(aa & OUT_DRIVER_MASK, m[SLOT_DRV]);
    chk(ab & CONV_CLOCK_MASK, m[SLOT_CONV]);
  endtask : chk_en
  // one access; the answer is checked in the cycle after it is taken
  task automatic acc(input logic w, input logic r, input addr_t a, input word_t d);
    int s;
    word_t old;
    logic pr;
    s = slot(a);
    old = (s >= 0) ? m[s] : 16'h0000;
    pr = w && a == CONV_CLOCK_OFFSET && d[3] && d[2] && old[3:2] == 2'b00;
    @(posedge ref_clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    if (w && s >= 0) m[s] = d & REG_MASK[s];
    #1;
    chk(reg_rdata_out, r ? old : 16'h0000);
    chk({15'h0, reg_rvalid_out}, {15'h0, r});
    chk({15'h0, reg_addr_err_out}, {15'h0, (w | r) && s < 0});
    chk({15'h0, adc_pair_start_out}, {15'h0, pr});
    chk_en();
  endtask : acc
  // reset for 6 cycles, then reset values everywhere
  task automatic do_reset();
    @(posedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    m = REG_RESET;
    nrst_in <= 1'b1;
    #1;
    chk_en();
    for (int i = 0; i < NUM_REGS; i++) acc(1'b0, 1'b1, REG_OFFSET[i], 16'h0000);
    $display("test reset done");
  endtask : do_reset
  // counts and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    #40000;
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    nrst_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    void'($urandom(34));
    do_reset();
    acc(1'b1, 1'b0, 8'h0b, 16'h200c);
    acc(1'b1, 1'b1, 8'h0b, 16'h200c);
    acc(1'b1, 1'b1, 8'h0b, 16'h0000);
    acc(1'b1, 1'b1, 8'h0c, 16'hffff);
    acc(1'b0, 1'b1, 8'h08, 16'h0000);
    $display("test corners done");
    for (int i = 0; i < NUM_REGS; i++)
      for (int b = 0; b < 16; b++)
        acc(1'b1, 1'b1, REG_OFFSET[i], word_t'(1 << b));
    $display("test walking bits done");
    repeat (400)
      acc(1'($urandom), 1'($urandom), 8'h08 + 8'($urandom % 5), word_t'($urandom));
    $display("test random done");
    do_reset();
    stop_test();
  end
endmodule : codec_power_enable_regs_tb
bind codec_power_enable_regs codec_power_enable_regs_checker chk_inst (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .reg_addr_err_out(reg_addr_err_out), .right_pga_on_out(right_pga_on_out),
  .left_pga_on_out(left_pga_on_out), .adc_highpass_on_out(adc_highpass_on_out),
  .timeout_slow_clock_on_out(timeout_slow_clock_on_out),
  .right_adc_on_out(right_adc_on_out), .left_adc_on_out(left_adc_on_out),
  .adc_pair_start_out(adc_pair_start_out));
